// [design/mae_defines.svh]
/*
 * Offsets, field positions and reset values for the misc arithmetic executor.
 * Assumes inclusion by bare name from the executor module.
 */
`ifndef MAE_DEFINES_SVH
`define MAE_DEFINES_SVH

// Register offsets on the plain register port
`define MAE_ADDR_STATUS 4'h0
`define MAE_ADDR_MASK 4'h1
`define MAE_ADDR_STATE 4'h2
`define MAE_ADDR_ACC 4'h3

// Interrupt status and mask bit positions
`define MAE_EV_CONV_DONE 0
`define MAE_EV_WDT_EXPIRE 1
`define MAE_EV_BACKUP 2
`define MAE_EV_SKIP 3

// State register bit positions
`define MAE_ST_WDT_FLAG 0
`define MAE_ST_CONV_FLAG 1
`define MAE_ST_CLOCK_RC 2
`define MAE_ST_BACKUP_ARMED 3
`define MAE_ST_WDT_STOP_EN 4

// Converter control bit that selects comparator mode
`define MAE_COMPARATOR_BIT 3

// Reset values
`define MAE_RST_NIBBLE 4'h0
`define MAE_RST_EVENTS 4'h0
`define MAE_RST_BYTE 8'h00
`define MAE_ZERO_NIBBLE 4'h0

`endif

// [design/mae_pkg.sv]
/*
 * Types shared by the misc arithmetic executor and its surroundings.
 * Assumes the decode stage supplies an already decoded operation.
 */
package mae_pkg;

    typedef enum logic [3:0] {
        OP_NONE           = 4'h0,
        OP_ADD_IMM        = 4'h1,
        OP_CONV_START     = 4'h2,
        OP_ADD_MEM        = 4'h3,
        OP_ADD_MEM_CARRY  = 4'h4,
        OP_WDT_TEST       = 4'h5,
        OP_CERAMIC        = 4'h6,
        OP_RC             = 4'h7,
        OP_BACKUP_DETECT  = 4'h8,
        OP_BACKUP_PLAIN   = 4'h9,
        OP_BACKUP_ENABLE  = 4'hA,
        OP_WDT_STOP_EN    = 4'hB,
        OP_CONV_TEST      = 4'hC,
        OP_OTHER          = 4'hD
    } mae_op_type;

    typedef struct packed {
        logic valid;
        mae_op_type op;
        logic [3:0] imm;
        logic [3:0] mem;
    } mae_instr_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } mae_bus_req_type;

endpackage

// [design/mae_exec.sv]
/*
 * Executor for the add, converter start/test, watchdog test, clock select,
 * RAM back-up and watchdog stop instructions of a 4-bit CPU.
 * Assumes one decoded instruction per clk_sys cycle from the decode stage,
 * the RAM nibble at the data pointer already fetched, and single-cycle
 * register port strobes that never overlap.
 */
`timescale 1ns/1ps
`include "mae_defines.svh"

module mae_exec (
    input wire logic clk_sys,
    input wire logic reset,
    input wire mae_pkg::mae_instr_type instr,
    input wire logic [3:0] converter_control_reg,
    input wire logic converter_irq_enable_bit,
    input wire logic conversion_done_event,
    input wire logic watchdog_expire_event,
    input wire mae_pkg::mae_bus_req_type bus_req,
    output logic [7:0] bus_rdata,
    output logic [3:0] accumulator,
    output logic carry_flag,
    output logic skip_pending,
    output logic conversion_start,
    output logic comparator_start,
    output logic clock_select_rc,
    output logic backup_enter,
    output logic backup_keep_detect,
    output logic watchdog_stop_enable,
    output logic irq
);
    import mae_pkg::*;

    // 4-bit add with carry in; bit 4 is the carry out of bit 3
    function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b,
                                        input logic cin);
        add4 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    endfunction

    logic [3:0] acc_ff;
    logic carry_ff;
    logic skip_ff;
    logic conv_flag_ff;
    logic wdt_flag_ff;
    logic conv_start_ff;
    logic comp_start_ff;
    logic clock_rc_ff;
    logic backup_armed_ff;
    logic backup_enter_ff;
    logic backup_detect_ff;
    logic wdt_stop_en_ff;
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic [7:0] rdata_ff;

    logic exec;
    logic [4:0] sum_imm;
    logic [4:0] sum_mem;
    logic [4:0] sum_memc;
    logic nxt_skip;
    logic conv_clear;
    logic wdt_clear;
    logic backup_go;
    logic [3:0] events;

    ////////////////////////////////////////////////////////////////////////
    // Execute qualification and arithmetic

    assign exec = instr.valid && !skip_ff;
    assign sum_imm = add4(acc_ff, instr.imm, 1'b0);
    assign sum_mem = add4(acc_ff, instr.mem, 1'b0);
    assign sum_memc = add4(acc_ff, instr.mem, carry_ff);
    assign backup_go = exec && backup_armed_ff &&
                       (instr.op == OP_BACKUP_DETECT || instr.op == OP_BACKUP_PLAIN);

    always_comb begin
        nxt_skip = 1'b0;
        conv_clear = 1'b0;
        wdt_clear = 1'b0;
        if (exec) begin
            case (instr.op)
                OP_ADD_IMM: begin
                    nxt_skip = !sum_imm[4];
                end
                OP_CONV_START: begin
                    conv_clear = 1'b1;
                end
                OP_WDT_TEST: begin
                    nxt_skip = wdt_flag_ff;
                    wdt_clear = wdt_flag_ff;
                end
                OP_CONV_TEST: begin
                    if (!converter_irq_enable_bit) begin
                        nxt_skip = conv_flag_ff;
                        conv_clear = conv_flag_ff;
                    end
                end
                default: begin
                    nxt_skip = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator and carry

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            acc_ff <= `MAE_RST_NIBBLE;
        end else if (exec) begin
            case (instr.op)
                OP_ADD_IMM: acc_ff <= sum_imm[3:0];
                OP_ADD_MEM: acc_ff <= sum_mem[3:0];
                OP_ADD_MEM_CARRY: acc_ff <= sum_memc[3:0];
                default: acc_ff <= acc_ff;
            endcase
        end
    end

    // Only add-with-carry touches the carry
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            carry_ff <= 1'b0;
        end else if (exec && instr.op == OP_ADD_MEM_CARRY) begin
            carry_ff <= sum_memc[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Skip of the following instruction

    // A suppressed instruction consumes the pending skip
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            skip_ff <= 1'b0;
        end else if (instr.valid) begin
            skip_ff <= nxt_skip;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter and watchdog flags

    // Peripheral set wins over an instruction clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_flag_ff <= 1'b0;
        end else if (conversion_done_event) begin
            conv_flag_ff <= 1'b1;
        end else if (conv_clear) begin
            conv_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wdt_flag_ff <= 1'b0;
        end else if (watchdog_expire_event) begin
            wdt_flag_ff <= 1'b1;
        end else if (wdt_clear) begin
            wdt_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_start_ff <= 1'b0;
            comp_start_ff <= 1'b0;
        end else begin
            conv_start_ff <= exec && instr.op == OP_CONV_START &&
                             !converter_control_reg[`MAE_COMPARATOR_BIT];
            comp_start_ff <= exec && instr.op == OP_CONV_START &&
                             converter_control_reg[`MAE_COMPARATOR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock source, back-up and watchdog stop

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clock_rc_ff <= 1'b0;
        end else if (exec && instr.op == OP_CERAMIC) begin
            clock_rc_ff <= 1'b0;
        end else if (exec && instr.op == OP_RC) begin
            clock_rc_ff <= 1'b1;
        end
    end

    // Arming is one-shot so a stray back-up later cannot power down
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            backup_armed_ff <= 1'b0;
        end else if (exec && instr.op == OP_BACKUP_ENABLE) begin
            backup_armed_ff <= 1'b1;
        end else if (backup_go) begin
            backup_armed_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            backup_enter_ff <= 1'b0;
            backup_detect_ff <= 1'b0;
        end else begin
            backup_enter_ff <= backup_go;
            if (backup_go) begin
                backup_detect_ff <= (instr.op == OP_BACKUP_DETECT);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wdt_stop_en_ff <= 1'b0;
        end else if (exec && instr.op == OP_WDT_STOP_EN) begin
            wdt_stop_en_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and register port

    always_comb begin
        events = `MAE_RST_EVENTS;
        events[`MAE_EV_CONV_DONE] = conversion_done_event;
        events[`MAE_EV_WDT_EXPIRE] = watchdog_expire_event;
        events[`MAE_EV_BACKUP] = backup_go;
        events[`MAE_EV_SKIP] = exec && nxt_skip;
    end

    // Write-one-to-clear; a new event in the same cycle stays set
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_ff <= `MAE_RST_EVENTS;
        end else if (bus_req.wr && bus_req.addr == `MAE_ADDR_STATUS) begin
            status_ff <= (status_ff & ~bus_req.wdata[3:0]) | events;
        end else begin
            status_ff <= status_ff | events;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mask_ff <= `MAE_RST_EVENTS;
        end else if (bus_req.wr && bus_req.addr == `MAE_ADDR_MASK) begin
            mask_ff <= bus_req.wdata[3:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_ff <= `MAE_RST_BYTE;
        end else if (!bus_req.rd) begin
            rdata_ff <= `MAE_RST_BYTE;
        end else if (bus_req.addr == `MAE_ADDR_STATUS) begin
            rdata_ff <= {`MAE_ZERO_NIBBLE, status_ff};
        end else if (bus_req.addr == `MAE_ADDR_MASK) begin
            rdata_ff <= {`MAE_ZERO_NIBBLE, mask_ff};
        end else if (bus_req.addr == `MAE_ADDR_STATE) begin
            rdata_ff <= {3'h0, wdt_stop_en_ff, backup_armed_ff, clock_rc_ff,
                         conv_flag_ff, wdt_flag_ff};
        end else if (bus_req.addr == `MAE_ADDR_ACC) begin
            rdata_ff <= {3'h0, carry_ff, acc_ff};
        end else begin
            rdata_ff <= `MAE_RST_BYTE;
        end
    end

    assign bus_rdata = rdata_ff;
    assign accumulator = acc_ff;
    assign carry_flag = carry_ff;
    assign skip_pending = skip_ff;
    assign conversion_start = conv_start_ff;
    assign comparator_start = comp_start_ff;
    assign clock_select_rc = clock_rc_ff;
    assign backup_enter = backup_enter_ff;
    assign backup_keep_detect = backup_detect_ff;
    assign watchdog_stop_enable = wdt_stop_en_ff;
    assign irq = |(status_ff & mask_ff);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_add_imm_sum: assert property (@(posedge clk_sys) disable iff (reset)
        exec && instr.op == OP_ADD_IMM |=>
        acc_ff == 4'((5'($past(acc_ff)) + 5'($past(instr.imm)))) && $stable(carry_ff))
        else $error("add-immediate sum or carry wrong");

    a_add_imm_skip: assert property (@(posedge clk_sys) disable iff (reset)
        exec && instr.op == OP_ADD_IMM |=>
        skip_ff == ((5'($past(acc_ff)) + 5'($past(instr.imm))) < 5'h10))
        else $error("add-immediate skip decision wrong");

    a_conv_start_mode: assert property (@(posedge clk_sys) disable iff (reset)
        exec && instr.op == OP_CONV_START |=>
        (conv_start_ff != comp_start_ff) &&
        comp_start_ff == $past(converter_control_reg[`MAE_COMPARATOR_BIT]) &&
        (!conv_flag_ff || $past(conversion_done_event)))
        else $error("conversion start mode or flag clear wrong");

    a_add_mem_carry: assert property (@(posedge clk_sys) disable iff (reset)
        exec && instr.op == OP_ADD_MEM |=>
        acc_ff == 4'((5'($past(acc_ff)) + 5'($past(instr.mem)))) && $stable(carry_ff))
        else $error("add-memory result or carry wrong");

    a_amc_result: assert property (@(posedge clk_sys) disable iff (reset)
        exec && instr.op == OP_ADD_MEM_CARRY |=>
        {carry_ff, acc_ff} == 5'($past(acc_ff)) + 5'($past(instr.mem)) + 5'($past(carry_ff)))
        else $error("add-with-carry result wrong");

    a_wdt_test_skip: assert property (@(posedge clk_sys) disable iff (reset)
        exec && instr.op == OP_WDT_TEST && wdt_flag_ff && !watchdog_expire_event |=>
        skip_ff && !wdt_flag_ff)
        else $error("watchdog test skip or clear wrong");

    a_clock_select: assert property (@(posedge clk_sys) disable iff (reset)
        exec && (instr.op == OP_CERAMIC || instr.op == OP_RC) |=>
        clock_rc_ff == ($past(instr.op) == OP_RC))
        else $error("clock source select wrong");

    a_backup_gate: assert property (@(posedge clk_sys) disable iff (reset)
        backup_enter_ff |-> $past(backup_armed_ff, 1) && !backup_armed_ff)
        else $error("back-up entered without enable");

    a_backup_detect: assert property (@(posedge clk_sys) disable iff (reset)
        backup_go |=> backup_enter_ff && backup_detect_ff == ($past(instr.op) == OP_BACKUP_DETECT))
        else $error("back-up detect qualifier wrong");

    a_conv_test_nop: assert property (@(posedge clk_sys) disable iff (reset)
        exec && instr.op == OP_CONV_TEST && converter_irq_enable_bit |=>
        !skip_ff && (conv_flag_ff == ($past(conv_flag_ff) || $past(conversion_done_event))))
        else $error("converter test not a no-op");

    a_skip_suppress: assert property (@(posedge clk_sys) disable iff (reset)
        instr.valid && skip_ff |=> !skip_ff && $stable(acc_ff) && $stable(carry_ff))
        else $error("skipped instruction executed");

endmodule // mae_exec

// [verif/mae_exec_tb_top.sv]
/*
 * Self-checking bench for the misc arithmetic executor: directed and
 * random instruction and register traffic against a cycle model.
 * Assumes the decoded operation enum and structs of mae_pkg.
 */
`timescale 1ns/1ps

module mae_exec_tb_top;
    import mae_pkg::*;

    logic clk_sys;
    logic reset;
    mae_instr_type instr;
    logic [3:0] converter_control_reg;
    logic converter_irq_enable_bit;
    logic conversion_done_event;
    logic watchdog_expire_event;
    mae_bus_req_type bus_req;
    logic [7:0] bus_rdata;
    logic [3:0] accumulator;
    logic carry_flag;
    logic skip_pending;
    logic conversion_start;
    logic comparator_start;
    logic clock_select_rc;
    logic backup_enter;
    logic backup_keep_detect;
    logic watchdog_stop_enable;
    logic irq;

    int errors;
    int compares;
    mae_instr_type d_instr;
    mae_bus_req_type d_bus;
    logic [3:0] d_ctrl;
    logic d_irqb, d_ce, d_we, d_rst;
    logic [3:0] m_acc, m_st, m_mask;
    logic m_cy, m_skip, m_wdf, m_cdf, m_rc, m_arm, m_stop, m_cs, m_cmp, m_be, m_kd;
    logic [7:0] m_rdata;
    logic [15:0] r;

    mae_exec dut (
        .clk_sys(clk_sys),
        .reset(reset),
        .instr(instr),
        .converter_control_reg(converter_control_reg),
        .converter_irq_enable_bit(converter_irq_enable_bit),
        .conversion_done_event(conversion_done_event),
        .watchdog_expire_event(watchdog_expire_event),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .accumulator(accumulator),
        .carry_flag(carry_flag),
        .skip_pending(skip_pending),
        .conversion_start(conversion_start),
        .comparator_start(comparator_start),
        .clock_select_rc(clock_select_rc),
        .backup_enter(backup_enter),
        .backup_keep_detect(backup_keep_detect),
        .watchdog_stop_enable(watchdog_stop_enable),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Model step for the inputs sampled at this edge; reads see pre-edge state
    task automatic model_edge();
        logic [4:0] s;
        m_cs = 1'b0;
        m_cmp = 1'b0;
        m_be = 1'b0;
        m_rdata = 8'h00;
        if (reset) begin
            {m_acc, m_st, m_mask} = 12'h000;
            {m_cy, m_skip, m_wdf, m_cdf, m_rc, m_arm, m_stop, m_kd} = 8'h00;
            return;
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                4'h0: m_rdata = {4'h0, m_st};
                4'h1: m_rdata = {4'h0, m_mask};
                4'h2: m_rdata = {3'h0, m_stop, m_arm, m_rc, m_cdf, m_wdf};
                4'h3: m_rdata = {3'h0, m_cy, m_acc};
                default: m_rdata = 8'h00;
            endcase
        end
        if (bus_req.wr && bus_req.addr == 4'h0) m_st = m_st & ~bus_req.wdata[3:0];
        if (bus_req.wr && bus_req.addr == 4'h1) m_mask = bus_req.wdata[3:0];
        if (instr.valid && m_skip) begin
            m_skip = 1'b0;
        end else if (instr.valid) begin
            case (instr.op)
                OP_ADD_IMM: begin
                    s = {1'b0, m_acc} + {1'b0, instr.imm};
                    m_acc = s[3:0];
                    m_skip = !s[4];
                end
                OP_ADD_MEM: m_acc = m_acc + instr.mem;
                OP_ADD_MEM_CARRY: begin
                    s = {1'b0, m_acc} + {1'b0, instr.mem} + {4'h0, m_cy};
                    {m_cy, m_acc} = s;
                end
                OP_CONV_START: begin
                    m_cdf = 1'b0;
                    m_cs = !converter_control_reg[3];
                    m_cmp = converter_control_reg[3];
                end
                OP_WDT_TEST: begin
                    m_skip = m_wdf;
                    m_wdf = 1'b0;
                end
                OP_CERAMIC: m_rc = 1'b0;
                OP_RC: m_rc = 1'b1;
                OP_BACKUP_ENABLE: m_arm = 1'b1;
                OP_BACKUP_DETECT, OP_BACKUP_PLAIN: begin
                    if (m_arm) begin
                        m_be = 1'b1;
                        m_kd = (instr.op == OP_BACKUP_DETECT);
                        m_arm = 1'b0;
                        m_st[2] = 1'b1;
                    end
                end
                OP_WDT_STOP_EN: m_stop = 1'b1;
                OP_CONV_TEST: begin
                    if (!converter_irq_enable_bit) begin
                        m_skip = m_cdf;
                        m_cdf = 1'b0;
                    end
                end
                default: ;
            endcase
            // Skip decided by an executed instruction raises its status bit
            if (m_skip) m_st[3] = 1'b1;
        end
        if (conversion_done_event) {m_cdf, m_st[0]} = 2'b11;
        if (watchdog_expire_event) {m_wdf, m_st[1]} = 2'b11;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One clock: drive at the rising edge, compare at the falling edge
    task automatic cyc();
        @(posedge clk_sys);
        model_edge();
        reset <= d_rst;
        instr <= d_instr;
        bus_req <= d_bus;
        converter_control_reg <= d_ctrl;
        converter_irq_enable_bit <= d_irqb;
        conversion_done_event <= d_ce;
        watchdog_expire_event <= d_we;
        d_instr = '0;
        d_bus = '0;
        {d_ce, d_we} = 2'b00;
        @(negedge clk_sys);
        chk_val({4'h0, accumulator}, {4'h0, m_acc}, "acc");
        chk_bit(carry_flag, m_cy, "carry");
        chk_bit(skip_pending, m_skip, "skip");
        chk_bit(conversion_start, m_cs, "conv start");
        chk_bit(comparator_start, m_cmp, "cmp start");
        chk_bit(clock_select_rc, m_rc, "clock sel");
        chk_bit(backup_enter, m_be, "backup");
        chk_bit(backup_keep_detect, m_kd, "keep detect");
        chk_bit(watchdog_stop_enable, m_stop, "wdt stop");
        chk_bit(irq, |(m_st & m_mask), "irq");
        chk_val(bus_rdata, m_rdata, "rdata");
    endtask

    task automatic op(input mae_op_type o, input logic [3:0] i, input logic [3:0] m);
        d_instr = '{valid: 1'b1, op: o, imm: i, mem: m};
        cyc();
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        d_bus = '{wr: w, rd: !w, addr: a, wdata: d};
        cyc();
    endtask

    task automatic read_all();
        for (int a = 0; a < 4; a++) bus(1'b0, a[3:0], 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        test_done();
    end

    initial begin
        errors = 0;
        compares = 0;
        reset = 1'b1;
        instr = '0;
        bus_req = '0;
        converter_control_reg = 4'h0;
        converter_irq_enable_bit = 1'b0;
        conversion_done_event = 1'b0;
        watchdog_expire_event = 1'b0;
        {d_instr, d_bus, d_ctrl, d_irqb, d_ce, d_we, d_rst} = '0;
        d_rst = 1'b1;
        repeat (4) cyc();
        d_rst = 1'b0;
        // Overflow boundary, skip suppressing the next add, carry chain
        op(OP_ADD_IMM, 4'hF, 4'h0);
        op(OP_ADD_IMM, 4'h1, 4'h0);
        op(OP_ADD_IMM, 4'h1, 4'h0);
        op(OP_ADD_IMM, 4'h3, 4'h0);
        op(OP_NONE, 4'h0, 4'h0);
        op(OP_ADD_MEM, 4'h0, 4'hE);
        op(OP_ADD_MEM_CARRY, 4'h0, 4'hF);
        op(OP_ADD_MEM_CARRY, 4'h0, 4'hF);
        op(OP_ADD_MEM_CARRY, 4'h0, 4'h0);
        bus(1'b0, 4'h3, 8'h00);
        $display("test arith done");
        // Converter start in both modes, flag test disabled then enabled
        op(OP_CONV_START, 4'h0, 4'h0);
        d_ctrl = 4'h8;
        d_ce = 1'b1;
        op(OP_CONV_START, 4'h0, 4'h0);
        d_irqb = 1'b1;
        op(OP_CONV_TEST, 4'h0, 4'h0);
        d_irqb = 1'b0;
        bus(1'b0, 4'h2, 8'h00);
        op(OP_CONV_TEST, 4'h0, 4'h0);
        op(OP_CONV_TEST, 4'h0, 4'h0);
        op(OP_CONV_TEST, 4'h0, 4'h0);
        d_we = 1'b1;
        op(OP_WDT_TEST, 4'h0, 4'h0);
        op(OP_WDT_TEST, 4'h0, 4'h0);
        op(OP_WDT_TEST, 4'h0, 4'h0);
        op(OP_WDT_TEST, 4'h0, 4'h0);
        read_all();
        $display("test flags done");
        op(OP_RC, 4'h0, 4'h0);
        op(OP_CERAMIC, 4'h0, 4'h0);
        op(OP_RC, 4'h0, 4'h0);
        op(OP_WDT_STOP_EN, 4'h0, 4'h0);
        // Back-up refused until enabled, enable is consumed
        op(OP_BACKUP_DETECT, 4'h0, 4'h0);
        op(OP_BACKUP_PLAIN, 4'h0, 4'h0);
        op(OP_BACKUP_ENABLE, 4'h0, 4'h0);
        read_all();
        op(OP_BACKUP_DETECT, 4'h0, 4'h0);
        op(OP_BACKUP_PLAIN, 4'h0, 4'h0);
        op(OP_BACKUP_ENABLE, 4'h0, 4'h0);
        op(OP_BACKUP_PLAIN, 4'h0, 4'h0);
        read_all();
        $display("test clock backup done");
        // Mask, interrupt, W1C clear, unmapped place
        bus(1'b1, 4'h1, 8'hFF);
        bus(1'b1, 4'h0, 8'h01);
        bus(1'b1, 4'hF, 8'hFF);
        bus(1'b0, 4'hF, 8'h00);
        read_all();
        bus(1'b1, 4'h0, 8'h0F);
        bus(1'b1, 4'h1, 8'h00);
        read_all();
        $display("test registers done");
        // Mid-run reset must return every output and register to its reset value
        op(OP_RC, 4'h0, 4'h0);
        d_rst = 1'b1;
        cyc();
        cyc();
        d_rst = 1'b0;
        read_all();
        $display("test reset done");
        r = 16'h4ECF;
        repeat (1500) begin
            r = lfsr(r);
            d_instr = '{valid: r[0] | r[1], op: mae_op_type'(r[5:2] % 4'hE),
                        imm: r[9:6], mem: r[13:10]};
            d_ce = r[14] & r[15];
            r = lfsr(r);
            d_we = r[0] & r[1] & r[2];
            d_ctrl = r[7:4];
            d_irqb = r[8];
            if (r[11:9] == 3'h0) d_bus = '{wr: 1'b0, rd: 1'b1, addr: r[15:12], wdata: 8'h00};
            if (r[11:9] == 3'h1) d_bus = '{wr: 1'b1, rd: 1'b0, addr: {3'h0, r[12]},
                                           wdata: {r[15:13], r[7:3]}};
            cyc();
        end
        $display("test random done");
        test_done();
    end

endmodule // mae_exec_tb_top
